// ===== drive_sup_pkg.sv
package drive_sup_pkg;

	// ----------------------------------------------------------------
	// status output selection codes
	// ----------------------------------------------------------------
	localparam logic [4:0] SEL_STALL = 5'h07;
	localparam logic [4:0] SEL_OVERVOLT = 5'h08;
	localparam logic [4:0] SEL_UNDERVOLT = 5'h09;
	localparam logic [4:0] SEL_OVERTEMP = 5'h0A;
	localparam logic [4:0] SEL_REF_LOST = 5'h0B;
	localparam logic [4:0] SEL_RUNNING = 5'h0C;
	localparam logic [4:0] SEL_STOPPED = 5'h0D;
	localparam logic [4:0] SEL_STEADY = 5'h0E;
	localparam logic [4:0] SEL_SPEED_SEARCH = 5'h11;
	localparam logic [4:0] SEL_READY = 5'h14;

	// ----------------------------------------------------------------
	// fault relay mask bits and reference-loss actions
	// ----------------------------------------------------------------
	localparam int MASK_UNDERVOLT_BIT = 0;
	localparam int MASK_TRIP_BIT = 1;
	localparam int MASK_RETRY_BIT = 2;
	localparam logic [2:0] MASK_RESET = 3'h2;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_COAST = 2'h1;
	localparam logic [1:0] ACT_DECEL = 2'h2;

	// ----------------------------------------------------------------
	// serial link codes and framing
	// ----------------------------------------------------------------
	localparam logic [2:0] PROT_ASCII = 3'h0;
	localparam logic [2:0] PROT_RTU = 3'h7;
	localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
	localparam logic [1:0] STOP_BITS_ASCII = 2'h1;
	localparam logic [1:0] STOP_BITS_RTU = 2'h2;
	localparam logic [2:0] BAUD_1200 = 3'h0;
	localparam logic [2:0] BAUD_2400 = 3'h1;
	localparam logic [2:0] BAUD_4800 = 3'h2;
	localparam logic [2:0] BAUD_9600 = 3'h3;
	localparam logic [2:0] BAUD_19200 = 3'h4;
	localparam logic [4:0] STATION_MIN = 5'h01;
	localparam logic [4:0] STATION_MAX = 5'h1F;
	localparam logic [4:0] STATION_RESET = 5'h01;
	localparam logic [2:0] RUN_SRC_SERIAL = 3'h3;
	localparam logic [2:0] FREQ_SRC_SERIAL = 3'h5;
	localparam logic [2:0] FREQ_SRC_KEYPAD1 = 3'h0;
	localparam logic [2:0] FREQ_SRC_KEYPAD2 = 3'h1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ = 200_000_000;
	localparam int LOSS_UNIT_MS = 100;
	localparam int LOSS_TICK_CYCLES = CLOCK_HZ / 1000 * LOSS_UNIT_MS;
	localparam logic [7:0] LOSS_WAIT_RESET = 8'h0A;
	localparam logic [3:0] RETRY_RESET = 4'h0;
	localparam int BAUD_DIV_W = 18;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] status_sel;
		logic [2:0] fault_relay_enable_mask;
		logic [1:0] loss_action;
		logic [7:0] loss_wait_tenths;
		logic [2:0] protocol;
		logic [2:0] baud_sel;
		logic [4:0] station;
		logic [3:0] retry_count_setting;
	} cfg_t;

	typedef struct packed {
		logic stall;
		logic running;
		logic accel;
		logic decel;
		logic speed_search;
		logic ready;
	} drive_cond_t;

	typedef struct packed {
		logic trip_undervolt;
		logic trip_output_disable;
		logic trip_other;
	} fault_t;

	typedef struct packed {
		logic [3:0] data_bits;
		logic [1:0] stop_bits;
		logic [BAUD_DIV_W-1:0] baud_div;
		logic [4:0] station;
		logic station_valid;
		logic serial_control;
	} link_cfg_t;

	// clock cycles per bit for a baud code
	function automatic logic [BAUD_DIV_W-1:0] baud_divisor(input logic [2:0] code);
		unique case (code)
			BAUD_1200: return BAUD_DIV_W'(CLOCK_HZ / 1200);
			BAUD_2400: return BAUD_DIV_W'(CLOCK_HZ / 2400);
			BAUD_4800: return BAUD_DIV_W'(CLOCK_HZ / 4800);
			BAUD_19200: return BAUD_DIV_W'(CLOCK_HZ / 19200);
			default: return BAUD_DIV_W'(CLOCK_HZ / 9600);
		endcase
	endfunction

endpackage

// ===== ref_loss_monitor.sv
`timescale 1ns/1ps
module ref_loss_monitor #(
	parameter int TICK_CYCLES = drive_sup_pkg::LOSS_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic keypad_mode,
	input wire logic comm_fail,
	input wire logic analog_fail,
	input wire logic [7:0] wait_tenths,
	output logic lost
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 1) begin : g_chk
		$error("tick period must be at least one cycle");
	end

	typedef enum logic [1:0] {
		MON_CLEAR = 2'b00,
		MON_TIMING = 2'b01,
		MON_LOST = 2'b11
	} mon_state_t;

	mon_state_t state_ff, nxt_state;
	logic [TW-1:0] tick_ff, nxt_tick;
	logic [7:0] tenths_ff, nxt_tenths;
	logic loss_cond;

	// ----------------------------------------------------------------
	// loss timer: condition must hold without a break for the wait
	// ----------------------------------------------------------------
	always_comb begin
		loss_cond = keypad_mode ? comm_fail : analog_fail;
		nxt_state = state_ff;
		nxt_tick = tick_ff;
		nxt_tenths = tenths_ff;
		unique case (state_ff)
			MON_CLEAR: begin
				if (loss_cond) begin
					nxt_state = MON_TIMING;
					nxt_tick = '0;
					nxt_tenths = '0;
				end
			end
			MON_TIMING: begin
				if (!loss_cond) begin
					nxt_state = MON_CLEAR; // any break restarts the wait
				end else if (tenths_ff >= wait_tenths) begin
					nxt_state = MON_LOST;
				end else if (tick_ff == TW'(TICK_CYCLES - 1)) begin
					nxt_tick = '0;
					nxt_tenths = tenths_ff + 8'h01;
				end else begin
					nxt_tick = tick_ff + TW'(1);
				end
			end
			MON_LOST: begin
				if (!loss_cond) begin
					nxt_state = MON_CLEAR;
				end
			end
			default: nxt_state = MON_CLEAR;
		endcase
	end

	// registers of the loss timer
	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= MON_CLEAR;
			tick_ff <= '0;
			tenths_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			tick_ff <= nxt_tick;
			tenths_ff <= nxt_tenths;
		end
	end

	assign lost = (state_ff == MON_LOST);

endmodule

// ===== fault_relay_ctrl.sv
`timescale 1ns/1ps
module fault_relay_ctrl (
	input wire logic clock,
	input wire logic srst,
	input wire drive_sup_pkg::fault_t faults,
	input wire logic fault_reset,
	input wire logic retry_load,
	input wire logic [2:0] mask,
	input wire logic [3:0] retry_setting,
	output logic relay_active,
	output logic [3:0] retries_left
);
	logic uv_lat_ff, nxt_uv_lat;
	logic trip_lat_ff, nxt_trip_lat;
	logic retry_zero_ff, nxt_retry_zero;
	logic [3:0] retry_ff, nxt_retry;
	logic relay_ff, nxt_relay;
	logic any_trip;

	// ----------------------------------------------------------------
	// trip latches, retry counter and relay decision
	// ----------------------------------------------------------------
	always_comb begin
		any_trip = faults.trip_undervolt | faults.trip_output_disable | faults.trip_other;
		// a trip in the cycle of a reset stays latched
		nxt_uv_lat = faults.trip_undervolt | (uv_lat_ff & ~fault_reset);
		nxt_trip_lat = faults.trip_other | (trip_lat_ff & ~fault_reset);
		nxt_retry = retry_ff;
		if (retry_load) begin
			nxt_retry = retry_setting;
		end else if (any_trip && retry_ff != 4'h0) begin
			nxt_retry = retry_ff - 4'h1;
		end
		nxt_retry_zero = (any_trip && !retry_load && retry_ff == 4'h1)
			| (retry_zero_ff & ~fault_reset);
		if (nxt_uv_lat) begin
			nxt_relay = mask[drive_sup_pkg::MASK_UNDERVOLT_BIT];
		end else begin
			nxt_relay = (nxt_trip_lat & mask[drive_sup_pkg::MASK_TRIP_BIT])
				| (nxt_retry_zero & mask[drive_sup_pkg::MASK_RETRY_BIT]);
		end
	end

	// registers of the relay logic
	always_ff @(posedge clock) begin
		if (srst) begin
			uv_lat_ff <= 1'b0;
			trip_lat_ff <= 1'b0;
			retry_zero_ff <= 1'b0;
			retry_ff <= 4'h0;
			relay_ff <= 1'b0;
		end else begin
			uv_lat_ff <= nxt_uv_lat;
			trip_lat_ff <= nxt_trip_lat;
			retry_zero_ff <= nxt_retry_zero;
			retry_ff <= nxt_retry;
			relay_ff <= nxt_relay;
		end
	end

	assign relay_active = relay_ff;
	assign retries_left = retry_ff;

endmodule

// ===== drive_status_output_and_ref_loss.sv
`timescale 1ns/1ps
module drive_status_output_and_ref_loss #(
	parameter int VOLT_W = 12,
	parameter int TEMP_W = 10,
	parameter logic [VOLT_W-1:0] OVERVOLT_LEVEL = 12'hC00,
	parameter logic [VOLT_W-1:0] UNDERVOLT_LEVEL = 12'h400,
	parameter logic [TEMP_W-1:0] OVERTEMP_LEVEL = 10'h300,
	parameter int LOSS_TICK_CYCLES = drive_sup_pkg::LOSS_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic cfg_wr,
	input wire drive_sup_pkg::cfg_t cfg_wdata,
	output drive_sup_pkg::cfg_t cfg_rdata,
	input wire drive_sup_pkg::drive_cond_t cond,
	input wire logic [VOLT_W-1:0] dc_link_voltage,
	input wire logic [TEMP_W-1:0] heatsink_temp,
	input wire drive_sup_pkg::fault_t faults,
	input wire logic fault_reset,
	input wire logic [2:0] run_command_source,
	input wire logic [2:0] frequency_reference_source,
	input wire logic comm_fail,
	input wire logic analog_fail,
	output logic status_open_collector_out,
	output logic relay_no_contact,
	output logic relay_nc_contact,
	output logic ref_lost,
	output logic hold_previous_freq,
	output logic coast_on_loss,
	output logic decel_stop_req,
	output logic [3:0] retries_left,
	output drive_sup_pkg::link_cfg_t link
);
	if (OVERVOLT_LEVEL <= UNDERVOLT_LEVEL) begin : g_chk_volt
		$error("overvoltage level must exceed undervoltage level");
	end
	if (VOLT_W < 2 || TEMP_W < 2) begin : g_chk_width
		$error("measurement widths too narrow");
	end

	// ----------------------------------------------------------------
	// configuration store
	// ----------------------------------------------------------------
	localparam drive_sup_pkg::cfg_t CFG_RESET = '{
		status_sel: drive_sup_pkg::SEL_RUNNING,
		fault_relay_enable_mask: drive_sup_pkg::MASK_RESET,
		loss_action: drive_sup_pkg::ACT_NONE,
		loss_wait_tenths: drive_sup_pkg::LOSS_WAIT_RESET,
		protocol: drive_sup_pkg::PROT_ASCII,
		baud_sel: drive_sup_pkg::BAUD_9600,
		station: drive_sup_pkg::STATION_RESET,
		retry_count_setting: drive_sup_pkg::RETRY_RESET
	};

	drive_sup_pkg::cfg_t cfg_ff, nxt_cfg;
	logic retry_load_ff, nxt_retry_load;

	// illegal protocol or baud codes leave the old setting in place
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_retry_load = cfg_wr;
		if (cfg_wr) begin
			nxt_cfg.status_sel = cfg_wdata.status_sel;
			nxt_cfg.fault_relay_enable_mask = cfg_wdata.fault_relay_enable_mask;
			nxt_cfg.loss_wait_tenths = cfg_wdata.loss_wait_tenths;
			nxt_cfg.station = cfg_wdata.station;
			nxt_cfg.retry_count_setting = cfg_wdata.retry_count_setting;
			if (cfg_wdata.loss_action <= drive_sup_pkg::ACT_DECEL) begin
				nxt_cfg.loss_action = cfg_wdata.loss_action;
			end
			if (cfg_wdata.protocol == drive_sup_pkg::PROT_ASCII
				|| cfg_wdata.protocol == drive_sup_pkg::PROT_RTU) begin
				nxt_cfg.protocol = cfg_wdata.protocol;
			end
			if (cfg_wdata.baud_sel <= drive_sup_pkg::BAUD_19200) begin
				nxt_cfg.baud_sel = cfg_wdata.baud_sel;
			end
		end
	end

	// configuration registers, factory defaults on reset
	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_ff <= CFG_RESET;
			retry_load_ff <= 1'b1;
		end else begin
			cfg_ff <= nxt_cfg;
			retry_load_ff <= nxt_retry_load;
		end
	end

	assign cfg_rdata = cfg_ff;

	// ----------------------------------------------------------------
	// reference-loss monitor
	// ----------------------------------------------------------------
	logic keypad_mode;
	logic lost_now;

	assign keypad_mode = (frequency_reference_source == drive_sup_pkg::FREQ_SRC_KEYPAD1)
		|| (frequency_reference_source == drive_sup_pkg::FREQ_SRC_KEYPAD2);

	ref_loss_monitor #(
		.TICK_CYCLES(LOSS_TICK_CYCLES)
	) u_loss (
		.clock(clock),
		.srst(srst),
		.keypad_mode(keypad_mode),
		.comm_fail(comm_fail),
		.analog_fail(analog_fail),
		.wait_tenths(cfg_ff.loss_wait_tenths),
		.lost(lost_now)
	);

	// ----------------------------------------------------------------
	// loss reaction outputs
	// ----------------------------------------------------------------
	logic lost_ff, nxt_lost;
	logic hold_ff, nxt_hold;
	logic coast_ff, nxt_coast;
	logic decel_ff, nxt_decel;

	always_comb begin
		nxt_lost = lost_now;
		nxt_hold = lost_now && (cfg_ff.loss_action == drive_sup_pkg::ACT_NONE);
		nxt_coast = lost_now && (cfg_ff.loss_action == drive_sup_pkg::ACT_COAST);
		nxt_decel = lost_now && (cfg_ff.loss_action == drive_sup_pkg::ACT_DECEL);
	end

	// reaction registers
	always_ff @(posedge clock) begin
		if (srst) begin
			lost_ff <= 1'b0;
			hold_ff <= 1'b0;
			coast_ff <= 1'b0;
			decel_ff <= 1'b0;
		end else begin
			lost_ff <= nxt_lost;
			hold_ff <= nxt_hold;
			coast_ff <= nxt_coast;
			decel_ff <= nxt_decel;
		end
	end

	assign ref_lost = lost_ff;
	assign hold_previous_freq = hold_ff;
	assign coast_on_loss = coast_ff;
	assign decel_stop_req = decel_ff;

	// ----------------------------------------------------------------
	// status open-collector output
	// ----------------------------------------------------------------
	logic over_volt;
	logic under_volt;
	logic over_temp;
	logic steady;
	logic sel_cond;
	logic status_ff, nxt_status;

	// selected condition; unknown codes keep the output open
	function automatic logic status_condition(input logic [4:0] sel,
		input drive_sup_pkg::drive_cond_t c, input logic ov, input logic uv,
		input logic oh, input logic lost, input logic stdy);
		unique case (sel)
			drive_sup_pkg::SEL_STALL: return c.stall;
			drive_sup_pkg::SEL_OVERVOLT: return ov;
			drive_sup_pkg::SEL_UNDERVOLT: return uv;
			drive_sup_pkg::SEL_OVERTEMP: return oh;
			drive_sup_pkg::SEL_REF_LOST: return lost;
			drive_sup_pkg::SEL_RUNNING: return c.running;
			drive_sup_pkg::SEL_STOPPED: return !c.running;
			drive_sup_pkg::SEL_STEADY: return stdy;
			drive_sup_pkg::SEL_SPEED_SEARCH: return c.speed_search;
			drive_sup_pkg::SEL_READY: return c.ready;
			default: return 1'b0;
		endcase
	endfunction

	always_comb begin
		over_volt = dc_link_voltage > OVERVOLT_LEVEL;
		under_volt = dc_link_voltage < UNDERVOLT_LEVEL;
		over_temp = heatsink_temp > OVERTEMP_LEVEL;
		steady = cond.running && !cond.accel && !cond.decel;
		sel_cond = status_condition(cfg_ff.status_sel, cond, over_volt, under_volt,
			over_temp, lost_ff, steady);
		nxt_status = sel_cond;
	end

	// output switch register, follows the condition every cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			status_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	assign status_open_collector_out = status_ff;

	// ----------------------------------------------------------------
	// fault relay; the common contact is shared by both pairs
	// ----------------------------------------------------------------
	logic relay_active;

	fault_relay_ctrl u_relay (
		.clock(clock),
		.srst(srst),
		.faults(faults),
		.fault_reset(fault_reset),
		.retry_load(retry_load_ff),
		.mask(cfg_ff.fault_relay_enable_mask),
		.retry_setting(cfg_ff.retry_count_setting),
		.relay_active(relay_active),
		.retries_left(retries_left)
	);

	assign relay_no_contact = relay_active;
	assign relay_nc_contact = !relay_active;

	// ----------------------------------------------------------------
	// serial link settings
	// ----------------------------------------------------------------
	drive_sup_pkg::link_cfg_t link_ff, nxt_link;

	always_comb begin
		nxt_link.data_bits = drive_sup_pkg::FRAME_DATA_BITS;
		nxt_link.stop_bits = (cfg_ff.protocol == drive_sup_pkg::PROT_RTU)
			? drive_sup_pkg::STOP_BITS_RTU : drive_sup_pkg::STOP_BITS_ASCII;
		nxt_link.baud_div = drive_sup_pkg::baud_divisor(cfg_ff.baud_sel);
		nxt_link.station = cfg_ff.station;
		nxt_link.station_valid = cfg_ff.station >= drive_sup_pkg::STATION_MIN
			&& cfg_ff.station <= drive_sup_pkg::STATION_MAX;
		nxt_link.serial_control = run_command_source == drive_sup_pkg::RUN_SRC_SERIAL
			&& frequency_reference_source == drive_sup_pkg::FREQ_SRC_SERIAL;
	end

	// link setting registers
	always_ff @(posedge clock) begin
		if (srst) begin
			link_ff <= '0;
		end else begin
			link_ff <= nxt_link;
		end
	end

	assign link = link_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	stall_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_STALL && cond.stall && $stable(cfg_ff)
		|=> status_open_collector_out) else $error("stall did not close output");
	overvolt_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_OVERVOLT && dc_link_voltage > OVERVOLT_LEVEL
		&& $stable(cfg_ff) |=> status_open_collector_out)
		else $error("overvoltage did not close output");
	undervolt_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_UNDERVOLT && $stable(cfg_ff)
		|=> status_open_collector_out == ($past(dc_link_voltage) < UNDERVOLT_LEVEL))
		else $error("undervoltage output wrong");
	stopped_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_STOPPED && $stable(cfg_ff)
		|=> status_open_collector_out != $past(cond.running))
		else $error("stopped output wrong");
	steady_open_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_STEADY && (cond.accel || cond.decel)
		&& $stable(cfg_ff) |=> !status_open_collector_out)
		else $error("steady closed while ramping");
	reserved_open_a: assert property (
		cfg_ff.status_sel == 5'h0F && $stable(cfg_ff) |=> !status_open_collector_out)
		else $error("reserved code closed output");
	contacts_differ_a: assert property (
		relay_no_contact != relay_nc_contact) else $error("relay contacts not complementary");
	uv_priority_a: assert property (
		faults.trip_undervolt && $stable(cfg_ff)
		|=> relay_no_contact
		== $past(cfg_ff.fault_relay_enable_mask[drive_sup_pkg::MASK_UNDERVOLT_BIT]))
		else $error("undervoltage trip lost priority");
	coast_follows_a: assert property (
		$rose(lost_now) && cfg_ff.loss_action == drive_sup_pkg::ACT_COAST && $stable(cfg_ff)
		|=> coast_on_loss && ref_lost && !hold_previous_freq)
		else $error("coast action missing");
	stop_bits_a: assert property (
		$stable(cfg_ff) && cfg_ff.protocol == drive_sup_pkg::PROT_RTU
		|=> link.stop_bits == 2'h2) else $error("modbus framing wrong");
	defaults_a: assert property (
		$fell(srst) |-> cfg_ff.loss_wait_tenths == 8'h0A && cfg_ff.loss_action == 2'h0
		&& cfg_ff.baud_sel == drive_sup_pkg::BAUD_9600)
		else $error("factory defaults wrong");
	overtemp_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_OVERTEMP && $stable(cfg_ff)
		|=> status_open_collector_out == ($past(heatsink_temp) > OVERTEMP_LEVEL))
		else $error("overheat output wrong");
	lost_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_REF_LOST && $stable(cfg_ff)
		|=> status_open_collector_out == $past(ref_lost)) else $error("lost output wrong");
	running_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_RUNNING && $stable(cfg_ff)
		|=> status_open_collector_out == $past(cond.running)) else $error("run output wrong");
	search_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_SPEED_SEARCH && $stable(cfg_ff)
		|=> status_open_collector_out == $past(cond.speed_search)) else $error("search output wrong");
	ready_closes_a: assert property (
		cfg_ff.status_sel == drive_sup_pkg::SEL_READY && $stable(cfg_ff)
		|=> status_open_collector_out == $past(cond.ready)) else $error("ready output wrong");
	relay_release_a: assert property (
		fault_reset && faults == '0 |=> !relay_no_contact && relay_nc_contact)
		else $error("relay held after fault reset");
	keypad_loss_a: assert property (
		keypad_mode && !comm_fail |=> !lost_now) else $error("keypad loss without failure");
	analog_loss_a: assert property (
		!keypad_mode && !analog_fail |=> !lost_now) else $error("analog loss without failure");
	hold_action_a: assert property (
		$rose(lost_now) && cfg_ff.loss_action == drive_sup_pkg::ACT_NONE && $stable(cfg_ff)
		|=> hold_previous_freq && !coast_on_loss && !decel_stop_req)
		else $error("hold action missing");
	decel_action_a: assert property (
		$rose(lost_now) && cfg_ff.loss_action == drive_sup_pkg::ACT_DECEL && $stable(cfg_ff)
		|=> decel_stop_req && !coast_on_loss && !hold_previous_freq)
		else $error("decel action missing");
	ascii_stop_a: assert property (
		$stable(cfg_ff) && cfg_ff.protocol == drive_sup_pkg::PROT_ASCII
		|=> link.stop_bits == 2'h1) else $error("ascii framing wrong");

endmodule

// ===== serial_host_model.sv
`timescale 1ns/1ps
// host on the serial link: hands the drive its source codes and station number
module serial_host_model (
	input wire logic keypad_ref,
	output logic [2:0] run_src,
	output logic [2:0] ref_src,
	output logic [4:0] station
);
	// ----------------------------------------------------------------
	// serial operation settings
	// ----------------------------------------------------------------
	// run and reference from the link, keypad reference on request
	assign run_src = drive_sup_pkg::RUN_SRC_SERIAL;
	assign ref_src = keypad_ref ? drive_sup_pkg::FREQ_SRC_KEYPAD1 : drive_sup_pkg::FREQ_SRC_SERIAL;
	// one drive on the link, so station 1 is unique and in range
	assign station = 5'h01;
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic cfg_wr = 1'b0;
	logic fault_reset = 1'b0;
	logic comm_fail = 1'b0;
	logic analog_fail = 1'b0;
	logic keypad_ref = 1'b0;
	logic [11:0] volt = 12'h800;
	logic [9:0] temp = 10'h100;
	logic [2:0] run_src;
	logic [2:0] ref_src;
	logic [4:0] host_station;
	logic so, no_c, nc_c, lost, hold, coast, decel;
	logic [3:0] retries;
	drive_sup_pkg::cfg_t cfg, rd;
	drive_sup_pkg::drive_cond_t cond = '0;
	drive_sup_pkg::fault_t faults = '0;
	drive_sup_pkg::link_cfg_t link;
	int fail_count = 0;
	int tests_run = 0;
	logic [4:0] sels [11] = '{5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
		5'h11, 5'h14, 5'h0F};
	always #2.5 clock = ~clock;
	serial_host_model host_u (.keypad_ref(keypad_ref), .run_src(run_src), .ref_src(ref_src),
		.station(host_station));
	drive_status_output_and_ref_loss #(.LOSS_TICK_CYCLES(10)) dut_u (.clock(clock), .srst(srst),
		.cfg_wr(cfg_wr), .cfg_wdata(cfg), .cfg_rdata(rd), .cond(cond), .dc_link_voltage(volt),
		.heatsink_temp(temp), .faults(faults), .fault_reset(fault_reset),
		.run_command_source(run_src), .frequency_reference_source(ref_src),
		.comm_fail(comm_fail), .analog_fail(analog_fail), .status_open_collector_out(so),
		.relay_no_contact(no_c), .relay_nc_contact(nc_c), .ref_lost(lost),
		.hold_previous_freq(hold), .coast_on_loss(coast), .decel_stop_req(decel),
		.retries_left(retries), .link(link));
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// one-cycle configuration write, then let cfg_rdata and link settle
	task automatic write_cfg();
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		tick(3);
	endtask
	// status model from the previous cycle's inputs
	function automatic logic model(input logic [4:0] s, input drive_sup_pkg::drive_cond_t c,
		input logic [11:0] v, input logic [9:0] t, input logic l);
		case (s)
			5'h07: return c.stall;
			5'h08: return v > 12'hC00;
			5'h09: return v < 12'h400;
			5'h0A: return t > 10'h300;
			5'h0B: return l;
			5'h0C: return c.running;
			5'h0D: return !c.running;
			5'h0E: return c.running && !c.accel && !c.decel;
			5'h11: return c.speed_search;
			5'h14: return c.ready;
			default: return 1'b0;
		endcase
	endfunction
	// relay: pulse one or more trip kinds, check the contacts, then apply a fault reset
	task automatic trip(input drive_sup_pkg::fault_t f, input logic exp);
		faults = f;
		tick(1);
		faults = '0;
		tick(1);
		check(no_c, exp);
		check(nc_c, !exp);
		fault_reset = 1'b1;
		tick(1);
		fault_reset = 1'b0;
		tick(1);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic exp;
		int n;
		void'($urandom(32'h32CA));
		cfg = '0;
		tick(16);
		srst = 1'b0;
		tick(2);
		check(rd.fault_relay_enable_mask, 3'h2);
		check(rd.loss_action, 2'h0);
		check(rd.loss_wait_tenths, 8'h0A);
		check(rd.baud_sel, drive_sup_pkg::BAUD_9600);
		check(nc_c, 1'b1);
		cfg = rd;
		// every selection code against random conditions
		foreach (sels[i]) begin
			cfg.status_sel = sels[i];
			write_cfg();
			repeat (20) begin
				cond = drive_sup_pkg::drive_cond_t'(6'($urandom));
				volt = 12'($urandom);
				temp = 10'($urandom);
				exp = model(sels[i], cond, volt, temp, lost);
				tick(1);
				check(so, exp);
			end
		end
		// protocol framing and baud codes
		cfg.station = host_station;
		for (int b = 0; b < 5; b++) begin
			cfg.protocol = (b % 2) ? drive_sup_pkg::PROT_RTU : drive_sup_pkg::PROT_ASCII;
			cfg.baud_sel = 3'(b);
			write_cfg();
			check(link.stop_bits, (b % 2) ? 2'h2 : 2'h1);
			check(link.data_bits, 4'h8);
			check(link.baud_div, 200_000_000 / (1200 << b));
			check(link.station, host_station);
			check(link.station_valid, 1'b1);
			check(link.serial_control, 1'b1);
		end
		// relay mask bits and undervoltage priority
		cfg.fault_relay_enable_mask = 3'h1;
		write_cfg();
		trip(3'b100, 1'b1);
		trip(3'b001, 1'b0);
		trip(3'b101, 1'b1);
		cfg.fault_relay_enable_mask = 3'h2;
		write_cfg();
		trip(3'b100, 1'b0);
		trip(3'b001, 1'b1);
		trip(3'b010, 1'b0);
		trip(3'b101, 1'b0);
		cfg.fault_relay_enable_mask = 3'h4;
		cfg.retry_count_setting = 4'h1;
		write_cfg();
		check(retries, 4'h1);
		trip(3'b010, 1'b1);
		// analog loss with ACT_NONE and ACT_DECEL, keypad loss with ACT_COAST
		cfg.status_sel = 5'h0B;
		cfg.loss_wait_tenths = 8'h02;
		for (int a = 0; a < 3; a++) begin
			cfg.loss_action = 2'(a);
			keypad_ref = a[0];
			write_cfg();
			n = 0;
			if (a[0]) comm_fail = 1'b1;
			else analog_fail = 1'b1;
			while (lost !== 1'b1 && n < 40) begin
				tick(1);
				n++;
			end
			if (n >= 40) begin
				fail_count++;
				test_done();
			end
			check(n >= 20 && n <= 24, 1'b1);
			tick(1);
			check({hold, coast, decel}, 3'b100 >> a);
			check(so, 1'b1);
			check(link.serial_control, !a[0]);
			comm_fail = 1'b0;
			analog_fail = 1'b0;
			tick(4);
			check(lost, 1'b0);
		end
		// second reset in mid-run restores factory defaults
		srst = 1'b1;
		tick(2);
		srst = 1'b0;
		tick(2);
		check(rd.loss_wait_tenths, 8'h0A);
		check(rd.loss_action, 2'h0);
		check(rd.baud_sel, drive_sup_pkg::BAUD_9600);
		check(link.stop_bits, 2'h1);
		test_done();
	end
endmodule
